/* File: osc_divider.sv */
// oscillator divider: phase clock, lagging bus clock and address strobe
// assumes clk is the oscillator, four clk periods per bus cycle
`timescale 1ns/1ps
module osc_divider (
    // clock and reset
    input wire logic clk,
    input wire logic rst,
    // link to the timer core
    osc_link_if.div lnk
);
    import timer_pkg::*;

    div_state_t q_r;
    div_state_t q_nxt;

    // ----------------------------------------------------------------
    // quarter-cycle sequencer
    // ----------------------------------------------------------------
    // outputs are decoded from the next phase so they leave flops directly
    always_comb begin
        q_nxt = q_r;
        q_nxt.phase = q_r.phase + 2'h1;
        q_nxt.tick = (q_r.phase == 2'h2); // one pulse per bus cycle
        q_nxt.phase_clk = lnk.int_en & q_nxt.phase[1];
        // bus clock is the phase clock delayed one quarter: 90 degrees late
        q_nxt.eclk = lnk.ext_en & ~(q_nxt.phase[1] ^ q_nxt.phase[0]);
        q_nxt.strobe = lnk.ext_en & (q_nxt.phase == 2'h1);
    end

    always_ff @(posedge clk) begin
        if (rst) begin
            q_r <= '0;
        end else begin
            q_r <= q_nxt;
        end
    end

    assign lnk.tick = q_r.tick;
    assign lnk.phase_clk = q_r.phase_clk;
    assign lnk.eclk = q_r.eclk;
    assign lnk.strobe = q_r.strobe;

    a_eclk_lag: assert property (@(posedge clk) disable iff (rst)
        (lnk.int_en && lnk.ext_en && $past(lnk.ext_en) && $past(lnk.int_en))
        |-> (q_r.eclk == $past(q_r.phase_clk)))
        else $error("bus clock does not lag phase clock by a quarter");

endmodule // osc_divider

/* File: osc_link_if.sv */
// carrier between the timer core and the oscillator divider
// assumes both ends run on the same clk
`timescale 1ns/1ps
interface osc_link_if;
    logic tick;
    logic phase_clk;
    logic eclk;
    logic strobe;
    logic int_en;
    logic ext_en;
    modport div (output tick, output phase_clk, output eclk, output strobe,
                 input int_en, input ext_en);
    modport core (input tick, input phase_clk, input eclk, input strobe,
                  output int_en, output ext_en);
endinterface

/* File: test_free_running_timer_compare_core.sv */
// self-checking bench for the timer core: byte bus reads and writes, port checks
// assumes the core's byte map from timer_consts.svh and clk at 100 MHz
`timescale 1ns/1ps
`include "timer_consts.svh"
module test_free_running_timer_compare_core;
    // ----------------------------------------------------------------
    // stimulus, observed outputs and bookkeeping
    // ----------------------------------------------------------------
    localparam logic [5:0] mask_two_addr = 6'h0F; // prescale and wrap enable
    logic clk = 1'b0;
    logic rst = 1'b1;
    logic [5:0] addr = 6'h00;
    logic rd_stb = 1'b0;
    logic wr_stb = 1'b0;
    logic [7:0] wdata = 8'h00;
    logic stop_req = 1'b0;
    logic test_mode = 1'b0;
    logic test_baud_clear = 1'b0;
    logic [7:0] rdata;
    logic [4:0] cmp_pins;
    logic [4:0] cmp_irq;
    logic wrap_irq;
    logic pacc_clock_tap;
    logic watchdog_clock_tap;
    logic internal_phase_clock;
    logic bus_clock;
    logic address_latch_strobe;
    logic [7:0] d, a, b, f, h, dd;
    logic [15:0] tgt;
    logic [4:0] pins_exp;
    logic wd_seen = 1'b0;
    int cyc = 0;
    int t0, c0, k, i, n, m;
    int n_mismatch = 0;
    int cmp_count = 0;

    timer_core dut (
        .clk(clk),
        .rst(rst),
        .addr(addr),
        .rd_stb(rd_stb),
        .wr_stb(wr_stb),
        .wdata(wdata),
        .rdata(rdata),
        .stop_req(stop_req),
        .test_mode(test_mode),
        .test_baud_clear(test_baud_clear),
        .cmp_pins(cmp_pins),
        .cmp_irq(cmp_irq),
        .wrap_irq(wrap_irq),
        .pacc_clock_tap(pacc_clock_tap),
        .watchdog_clock_tap(watchdog_clock_tap),
        .internal_phase_clock(internal_phase_clock),
        .bus_clock(bus_clock),
        .address_latch_strobe(address_latch_strobe)
    );

    // 100 MHz oscillator clock
    always #5 clk = ~clk;

    // edge counter gives exact spans; the slow tap must never fire in so short a run
    always @(posedge clk) begin
        cyc <= cyc + 1;
        if (watchdog_clock_tap === 1'b1) begin
            wd_seen <= 1'b1;
        end
    end

    // ----------------------------------------------------------------
    // bus tasks and comparison
    // ----------------------------------------------------------------
    task automatic check(input string what, input logic [15:0] seen, input logic [15:0] exp);
        cmp_count++;
        if (seen !== exp) begin
            n_mismatch++;
            $display("wrong value %s expected %h seen %h", what, exp, seen);
        end
    endtask

    // strobe for one edge; data is registered, so it is taken after the next edge
    task automatic rd(input logic [5:0] ad, output logic [7:0] dv);
        @(posedge clk);
        rd_stb <= 1'b1;
        addr <= ad;
        @(posedge clk);
        rd_stb <= 1'b0;
        #1;
        dv = rdata;
    endtask

    task automatic wr(input logic [5:0] ad, input logic [7:0] dv);
        @(posedge clk);
        wr_stb <= 1'b1;
        addr <= ad;
        wdata <= dv;
        @(posedge clk);
        wr_stb <= 1'b0;
        #1;
    endtask

    function automatic logic sig(input int w);
        case (w)
            0: return internal_phase_clock;
            1: return bus_clock;
            2: return pacc_clock_tap;
            default: return cmp_irq[w-3];
        endcase
    endfunction

    // bounded wait for an output level, sampled just after each edge
    task automatic wait_for(input int w, input logic lvl, input int lim);
        int cnt;
        cnt = 0;
        while (sig(w) !== lvl && cnt < lim) begin
            @(posedge clk);
            #1;
            cnt++;
        end
    endtask

    // internal clocks come back first, the bus clock only a bus cycle later
    task automatic startup(input int ts);
        wait_for(0, 1'b1, 20000);
        check("startup span", 16'((cyc - ts) >= 16240 && (cyc - ts) <= 16300), 16'h0001);
        check("bus clock held", 16'(bus_clock), 16'h0000);
        wait_for(1, 1'b1, 16);
        check("bus clock runs", 16'(bus_clock), 16'h0001);
    endtask

    task automatic tally_and_finish;
        $display("comparisons %0d mismatches %0d", cmp_count, n_mismatch);
        if (n_mismatch == 0 && cmp_count > 0) begin
            $display("DONE - PASS");
        end else begin
            $display("DONE - FAIL");
        end
        $finish;
    endtask

    // ----------------------------------------------------------------
    // test sequence
    // ----------------------------------------------------------------
    initial begin
        repeat (10) @(posedge clk);
        rst <= 1'b0;
        #1;
        t0 = cyc;
        // reset contents, unmapped read, one-time prescale write in the window
        rd(`A_CNT_HI, d);
        check("count high", {8'h00, d}, 16'h0000); // reset count
        rd(`A_OCR_FIRST, d);
        check("compare 0 high", {8'h00, d}, 16'h00FF);
        rd(`A_OCR_LAST, d);
        check("compare 4 low", {8'h00, d}, 16'h00FF);
        rd(`A_CMP_FLAGS, d);
        check("flags", {8'h00, d}, 16'h0000);
        rd(6'h3F, d);
        check("unmapped", {8'h00, d}, 16'h0000);
        wr(mask_two_addr, 8'h00);
        wr(mask_two_addr, 8'h83);
        rd(mask_two_addr, d);
        check("prescale once", {8'h00, d}, 16'h0080);
        repeat (100) @(posedge clk);
        rd(`A_CNT_LO, d);
        check("count still in delay", {8'h00, d}, 16'h0000);
        startup(t0);
        // phase relation of the derived clocks
        wait_for(0, 1'b0, 8);
        wait_for(0, 1'b1, 8);
        check("lag at phase rise", 16'(bus_clock), 16'h0000);
        @(posedge clk);
        #1;
        check("lag one clk", 16'(bus_clock), 16'h0001);
        n = 0;
        m = 0;
        for (k = 0; k < 40; k++) begin
            @(posedge clk);
            #1;
            n += (address_latch_strobe === 1'b1);
            m += (internal_phase_clock === 1'b1);
        end
        check("strobe count", 16'(n), 16'h000A); // one per bus cycle
        check("phase high count", 16'(m), 16'h0014);
        // accumulator tap spacing at the fastest prescale
        wait_for(2, 1'b1, 300);
        c0 = cyc;
        @(posedge clk);
        #1;
        wait_for(2, 1'b1, 300);
        check("acc tap period", 16'(cyc - c0), 16'h0100);
        // count rate over 40 clk, with load attempts in between that must be ignored
        rd(`A_CNT_LO, a);
        c0 = cyc;
        wr(`A_CNT_HI, 8'h55);
        wr(`A_CNT_LO, 8'hAA);
        repeat (c0 + 38 - cyc) @(posedge clk);
        rd(`A_CNT_LO, b);
        dd = b - a;
        check("count step", {8'h00, dd}, 16'h000A); // live low byte
        // high read holds the low byte; all four tick phases so a missing hold shows
        for (k = 0; k < 4; k++) begin
            repeat (k) @(posedge clk);
            rd(`A_CNT_LO, a);
            rd(`A_CNT_HI, h);
            rd(`A_CNT_LO, f);
            rd(`A_CNT_LO, b);
            dd = b - f;
            check("held low byte", {8'h00, dd}, 16'h0001);
        end
        // each channel: schedule a match 64 counts ahead, see flag, irq, pin, clear
        wr(`A_CMP_IRQ_EN, 8'h1F);
        wr(`A_CMP_PIN_ACT, 8'h1F);
        pins_exp = 5'h00;
        for (i = 0; i < 5; i++) begin
            rd(`A_CNT_HI, h);
            rd(`A_CNT_LO, a);
            tgt = {h, a} + 16'h0040;
            wr(`A_OCR_FIRST + 6'(2 * i), tgt[15:8]);
            wr(`A_OCR_FIRST + 6'(2 * i + 1), tgt[7:0]);
            rd(`A_CMP_FLAGS, d);
            check("flags early", {8'h00, d}, 16'h0000);
            wait_for(3 + i, 1'b1, 400);
            rd(`A_CNT_LO, a);
            dd = a - tgt[7:0];
            check("match moment", 16'(dd <= 8'h03), 16'h0001);
            pins_exp = pins_exp | 5'(1 << i);
            check("irq lines", 16'(cmp_irq), 16'(1 << i));
            check("pins", 16'(cmp_pins), 16'(pins_exp));
            rd(`A_CMP_FLAGS, d);
            check("flag set", {8'h00, d}, 16'(1 << i));
            repeat (300) @(posedge clk);
            #1;
            check("flag sticky", 16'(cmp_irq), 16'(1 << i));
            wr(`A_CMP_FLAGS, 8'(1 << i));
            rd(`A_CMP_FLAGS, d);
            check("flag cleared", {8'h00, d}, 16'h0000);
            check("irq cleared", 16'(cmp_irq), 16'h0000);
        end
        // stop freezes the counter and clocks; exit times the delay again
        @(posedge clk);
        stop_req <= 1'b1;
        repeat (20) @(posedge clk);
        #1;
        rd(`A_CNT_LO, a);
        repeat (100) @(posedge clk);
        #1;
        check("clocks off in stop", 16'(internal_phase_clock | bus_clock), 16'h0000);
        rd(`A_CNT_LO, b);
        check("count held in stop", {8'h00, b}, {8'h00, a});
        @(posedge clk);
        stop_req <= 1'b0;
        #1;
        t0 = cyc;
        startup(t0);
        rd(`A_WRAP_FLAG, d);
        check("no wrap yet", {8'h00, d}, 16'h0000);
        check("slow tap silent", 16'(wd_seen), 16'h0000);
        tally_and_finish();
    end

    // watchdog: two startup delays plus the tests fit well inside this span
    initial begin
        repeat (60000) @(posedge clk);
        n_mismatch++;
        tally_and_finish();
    end
endmodule // test_free_running_timer_compare_core

/* File: timer_consts.svh */
// constants for the free-running timer core: offsets, fields, resets, counts
// assumes a byte-wide processor bus and clk as the 4x oscillator clock
`ifndef TIMER_CONSTS_SVH
`define TIMER_CONSTS_SVH

// ----------------------------------------------------------------
// register offsets (byte addresses on the processor bus)
// ----------------------------------------------------------------
`define A_CNT_HI 6'h00
`define A_CNT_LO 6'h01
`define A_OCR_FIRST 6'h02
`define A_OCR_LAST 6'h0B
`define A_CMP_FLAGS 6'h0C
`define A_CMP_IRQ_EN 6'h0D
`define A_CMP_PIN_ACT 6'h0E
`define A_TIMER_MASK_TWO 6'h0F
`define A_WRAP_FLAG 6'h10

// ----------------------------------------------------------------
// fields and reset values
// ----------------------------------------------------------------
`define WRAP_IE_BIT 7
`define WRAP_FLAG_BIT 7
`define CNT_RST 16'h0000
`define OCR_RST 16'hFFFF
`define CNT_MAX 16'hFFFF

// ----------------------------------------------------------------
// timing counts
// ----------------------------------------------------------------
`define OSC_PER_BUS 3'h4
`define STARTUP_BUS_CYCLES 12'hFE0
`define PACC_TAP_MASK 15'h003F
`define WD_TAP_MASK 15'h7FFF

`endif

/* File: timer_core.sv */
// free-running timer core with five compare channels and clock taps
// assumes byte bus strobes synchronous to clk; clk is the 4x oscillator
`timescale 1ns/1ps
`include "timer_consts.svh"
module timer_core (
    // clock and reset
    input wire logic clk,
    input wire logic rst,
    // processor bus
    input wire logic [5:0] addr,
    input wire logic rd_stb,
    input wire logic wr_stb,
    input wire logic [7:0] wdata,
    output logic [7:0] rdata,
    // mode control
    input wire logic stop_req,
    input wire logic test_mode,
    input wire logic test_baud_clear,
    // timer outputs
    output logic [4:0] cmp_pins,
    output logic [4:0] cmp_irq,
    output logic wrap_irq,
    // clock taps
    output logic pacc_clock_tap,
    output logic watchdog_clock_tap,
    output logic internal_phase_clock,
    output logic bus_clock,
    output logic address_latch_strobe
);
    import timer_pkg::*;

    core_state_t q_r;
    core_state_t q_nxt;
    osc_link_if lnk ();

    default clocking cb @(posedge clk); endclocking
    default disable iff (rst);

    // ----------------------------------------------------------------
    // helpers
    // ----------------------------------------------------------------
    // low chain bits that must be all ones for one counter step
    function automatic logic [3:0] presc_mask(input logic [1:0] sel);
        case (sel)
            2'h0: presc_mask = 4'h0;
            2'h1: presc_mask = 4'h3;
            2'h2: presc_mask = 4'h7;
            default: presc_mask = 4'hF;
        endcase
    endfunction

    function automatic logic is_ocr(input logic [5:0] a);
        is_ocr = (a >= `A_OCR_FIRST) && (a <= `A_OCR_LAST);
    endfunction

    osc_divider u_div (
        .clk(clk),
        .rst(rst),
        .lnk(lnk)
    );

    logic run;
    logic step;
    assign run = (q_r.st == ST_INT_ONLY) || (q_r.st == ST_RUN);
    assign step = lnk.tick && run && ((q_r.chain[3:0] & presc_mask(q_r.presc))
                                      == presc_mask(q_r.presc));
    assign lnk.int_en = run;
    assign lnk.ext_en = (q_r.st == ST_RUN);

    // ----------------------------------------------------------------
    // next-state logic
    // ----------------------------------------------------------------
    always_comb begin
        logic [5:0] off;
        logic [2:0] ch;
        logic hit;
        off = '0;
        ch = '0;
        hit = 1'b0;
        q_nxt = q_r;
        q_nxt.pacc_tap = 1'b0;
        q_nxt.wd_tap = 1'b0;

        // baud divider runs on the raw oscillator, so stop cannot hold it
        if (test_mode && test_baud_clear) begin
            q_nxt.baud_div = '0;
        end else if (lnk.tick) begin
            q_nxt.baud_div = q_r.baud_div + 12'h001;
        end

        // clock sequencing: power-up and stop exit share the same delay
        case (q_r.st)
            ST_DELAY: begin
                if (lnk.tick && (q_r.baud_div - q_r.start_mark ==
                                 `STARTUP_BUS_CYCLES - 12'h001)) begin
                    q_nxt.st = ST_INT_ONLY;
                end
            end
            ST_INT_ONLY: begin
                if (lnk.tick) begin
                    q_nxt.st = ST_RUN;
                end
            end
            ST_RUN: begin
                if (stop_req) begin
                    q_nxt.st = ST_STOPPED;
                end
            end
            ST_STOPPED: begin
                if (!stop_req) begin
                    q_nxt.st = ST_DELAY;
                    q_nxt.start_mark = q_nxt.baud_div;
                end
            end
            default: q_nxt.st = ST_DELAY;
        endcase

        // shared chain: taps come off it before the prescale mask applies
        if (lnk.tick && run) begin
            q_nxt.chain = q_r.chain + 15'h0001;
            if ((q_r.chain & `PACC_TAP_MASK) == `PACC_TAP_MASK) begin
                q_nxt.pacc_tap = 1'b1;
                q_nxt.window_open = 1'b0;
            end
            if (q_r.chain == `WD_TAP_MASK) begin
                q_nxt.wd_tap = 1'b1;
            end
        end

        // bus writes; flag clears come before hardware sets so sets win
        if (wr_stb) begin
            if (is_ocr(addr)) begin
                off = addr - `A_OCR_FIRST;
                ch = {1'b0, off[2:1]} + (off[3] ? 3'h4 : 3'h0);
                if (off[0]) begin
                    q_nxt.ocr[ch][7:0] = wdata;
                end else begin
                    q_nxt.ocr[ch][15:8] = wdata;
                end
            end
            case (addr)
                `A_CMP_FLAGS: q_nxt.flags = q_r.flags & ~wdata[4:0];
                `A_CMP_IRQ_EN: q_nxt.irq_en = wdata[4:0];
                `A_CMP_PIN_ACT: q_nxt.pin_act = wdata[4:0];
                `A_WRAP_FLAG: begin
                    if (wdata[`WRAP_FLAG_BIT]) begin
                        q_nxt.wrap_flag = 1'b0;
                    end
                end
                `A_TIMER_MASK_TWO: begin
                    q_nxt.wrap_ie = wdata[`WRAP_IE_BIT];
                    // prescale is time-protected and takes one write only
                    if (q_r.window_open && !q_r.presc_done) begin
                        q_nxt.presc = wdata[1:0];
                        q_nxt.presc_done = 1'b1;
                    end
                end
                default: ;
            endcase
        end

        // counter has no load path at all, only the step below
        if (step) begin
            q_nxt.count = q_r.count + 16'h0001;
            if (q_r.count == `CNT_MAX) begin
                q_nxt.wrap_flag = 1'b1;
            end
        end

        // comparators sample once per bus cycle; pins act on first match only
        if (lnk.tick && run) begin
            for (int i = 0; i < 5; i++) begin
                hit = (q_r.count == q_r.ocr[i]);
                q_nxt.match_prev[i] = hit;
                if (hit) begin
                    q_nxt.flags[i] = 1'b1;
                    if (!q_r.match_prev[i] && q_r.pin_act[i]) begin
                        q_nxt.pins[i] = ~q_r.pins[i];
                    end
                end
            end
        end
        q_nxt.irq = q_nxt.flags & q_nxt.irq_en;
        q_nxt.wrap_irq = q_nxt.wrap_flag & q_nxt.wrap_ie;

        // low-byte latch: frozen one bus cycle by a high-byte read
        if (q_r.freeze != 3'h0) begin
            q_nxt.freeze = q_r.freeze - 3'h1;
        end
        if (rd_stb) begin
            off = addr - `A_OCR_FIRST;
            ch = {1'b0, off[2:1]} + (off[3] ? 3'h4 : 3'h0);
            case (addr)
                `A_CNT_HI: begin
                    q_nxt.rdata = q_r.count[15:8];
                    q_nxt.lo_hold = q_r.count[7:0];
                    // the read edge itself plus three more clk make one bus cycle
                    q_nxt.freeze = `OSC_PER_BUS - 3'h1;
                end
                `A_CNT_LO: q_nxt.rdata = (q_r.freeze != 3'h0) ?
                                         q_r.lo_hold : q_r.count[7:0];
                `A_CMP_FLAGS: q_nxt.rdata = {3'h0, q_r.flags};
                `A_CMP_IRQ_EN: q_nxt.rdata = {3'h0, q_r.irq_en};
                `A_CMP_PIN_ACT: q_nxt.rdata = {3'h0, q_r.pin_act};
                `A_TIMER_MASK_TWO: q_nxt.rdata = {q_r.wrap_ie, 5'h00, q_r.presc};
                `A_WRAP_FLAG: q_nxt.rdata = {q_r.wrap_flag, 7'h00};
                default: begin
                    if (is_ocr(addr)) begin
                        q_nxt.rdata = off[0] ? q_r.ocr[ch][7:0] : q_r.ocr[ch][15:8];
                    end else begin
                        q_nxt.rdata = 8'h00;
                    end
                end
            endcase
        end
    end

    // ----------------------------------------------------------------
    // state register
    // ----------------------------------------------------------------
    always_ff @(posedge clk) begin
        if (rst) begin
            q_r <= '0;
            q_r.st <= ST_DELAY;
            q_r.count <= `CNT_RST;
            q_r.ocr <= {5{`OCR_RST}};
            q_r.window_open <= 1'b1;
        end else begin
            q_r <= q_nxt;
        end
    end

    assign rdata = q_r.rdata;
    assign cmp_pins = q_r.pins;
    assign cmp_irq = q_r.irq;
    assign wrap_irq = q_r.wrap_irq;
    assign pacc_clock_tap = q_r.pacc_tap;
    assign watchdog_clock_tap = q_r.wd_tap;
    assign internal_phase_clock = lnk.phase_clk;
    assign bus_clock = lnk.eclk;
    assign address_latch_strobe = lnk.strobe;

    // ----------------------------------------------------------------
    // checks
    // ----------------------------------------------------------------
    a_reset_count_zero: assert property ($past(rst) |-> q_r.count == 16'h0000)
        else $error("counter not zero after reset");
    a_count_step_one: assert property (step |=> q_r.count == $past(q_r.count) + 16'h0001)
        else $error("counter did not advance by one");
    a_count_no_load: assert property (!step |=> $stable(q_r.count))
        else $error("counter moved without a step");
    a_wrap_sets_flag: assert property ((step && q_r.count == 16'hFFFF)
        |=> (q_r.count == 16'h0000) && q_r.wrap_flag && (q_r.wrap_irq == q_r.wrap_ie))
        else $error("wrap did not clear counter and set flag");
    for (genvar g = 0; g < 5; g++) begin : g_chk
        a_match_sets_flag: assert property ((lnk.tick && run && q_r.count == q_r.ocr[g])
            |=> q_r.flags[g] && (q_r.irq[g] == q_r.irq_en[g]))
            else $error("compare match did not set flag");
        // only the first tick of a match run may move the pin
        a_pin_toggle_once: assert property ((lnk.tick && run && q_r.count == q_r.ocr[g] &&
            !q_r.match_prev[g] && q_r.pin_act[g]) |=> q_r.pins[g] != $past(q_r.pins[g]))
            else $error("compare pin did not toggle on match");
        a_flag_sticky_set: assert property ((q_r.flags[g] &&
            !(wr_stb && addr == `A_CMP_FLAGS && wdata[g])) |=> q_r.flags[g])
            else $error("compare flag dropped without a clear");
    end
    a_freeze_lo_read: assert property ((rd_stb && addr == `A_CNT_HI) ##1
        (rd_stb && addr == `A_CNT_LO) |=> rdata == $past(q_r.count[7:0], 2))
        else $error("low byte not frozen after high byte read");
    // the hold must end after one bus cycle, or a lone low read goes stale
    a_freeze_ends_live: assert property ((rd_stb && addr == `A_CNT_HI) ##1
        (!(rd_stb && addr == `A_CNT_HI))[*3] ##1 (rd_stb && addr == `A_CNT_LO)
        |=> rdata == $past(q_r.count[7:0]))
        else $error("low byte still frozen after one bus cycle");

    // a gap of one idle clk between the two reads must still see the held byte
    a_freeze_gap_read: assert property ((rd_stb && addr == `A_CNT_HI) ##2
        (rd_stb && addr == `A_CNT_LO) |=> rdata == $past(q_r.count[7:0], 3))
        else $error("low byte not held across a short gap");

    // ----------------------------------------------------------------
    // divider chain and flag checks
    // ----------------------------------------------------------------
    // the baud divider only yields to the test-mode clear
    a_baud_test_clear: assert property ((test_mode && test_baud_clear)
        |=> q_r.baud_div == 12'h000)
        else $error("baud divider not cleared in test mode");
    a_baud_free_run: assert property ((!(test_mode && test_baud_clear) && lnk.tick)
        |=> q_r.baud_div == $past(q_r.baud_div) + 12'h001)
        else $error("baud divider did not advance on a tick");

    // wrap flag only drops on an explicit write-one clear
    a_wrap_flag_sticky: assert property ((q_r.wrap_flag &&
        !(wr_stb && addr == `A_WRAP_FLAG && wdata[`WRAP_FLAG_BIT])) |=> q_r.wrap_flag)
        else $error("wrap flag dropped without a clear");

    // taps are single-clk pulses, so downstream counters see one edge each
    a_pacc_tap_pulse: assert property (pacc_clock_tap |=> !pacc_clock_tap)
        else $error("accumulator tap longer than one clk");

    // stop freezes the counter along with the internal clocks
    a_stop_holds_count: assert property ((q_r.st == ST_STOPPED) |=> $stable(q_r.count))
        else $error("counter moved while stopped");

    a_window_stays_shut: assert property (!q_r.window_open |=> !q_r.window_open)
        else $error("write window reopened");
    a_presc_locked_once: assert property (q_r.presc_done |=> $stable(q_r.presc))
        else $error("prescale changed twice");
    a_ext_after_int: assert property ($rose(lnk.ext_en) |-> $past(lnk.int_en, 2))
        else $error("bus clock resumed before internal clocks");
    a_pacc_with_close: assert property (pacc_clock_tap |-> !q_r.window_open)
        else $error("accumulator tap fired with window open");

    c_counter_wrap: cover property (step && q_r.count == 16'hFFFF);
    c_compare_hit: cover property (q_r.flags[0] && q_r.pins[0]);
    c_stop_exit: cover property (q_r.st == ST_STOPPED ##1 q_r.st == ST_DELAY);
    c_presc_write: cover property ($rose(q_r.presc_done));

endmodule // timer_core

/* File: timer_pkg.sv */
// types shared by the timer core and its oscillator divider
// assumes timer_consts.svh for all numeric constants
package timer_pkg;

    typedef enum logic [1:0] {
        ST_DELAY,
        ST_INT_ONLY,
        ST_RUN,
        ST_STOPPED
    } clk_state_t;

    typedef struct packed {
        logic [1:0] phase;
        logic phase_clk;
        logic eclk;
        logic strobe;
        logic tick;
    } div_state_t;

    typedef struct packed {
        clk_state_t st;
        logic [11:0] baud_div;
        logic [11:0] start_mark;
        logic [14:0] chain;
        logic [15:0] count;
        logic [4:0][15:0] ocr;
        logic [4:0] flags;
        logic [4:0] irq_en;
        logic [4:0] pin_act;
        logic [4:0] match_prev;
        logic [4:0] pins;
        logic [4:0] irq;
        logic wrap_flag;
        logic wrap_ie;
        logic wrap_irq;
        logic [1:0] presc;
        logic presc_done;
        logic window_open;
        logic [7:0] lo_hold;
        logic [2:0] freeze;
        logic [7:0] rdata;
        logic pacc_tap;
        logic wd_tap;
    } core_state_t;

endpackage
